// ---- src/frt_consts.vh ----
`ifndef FRT_CONSTS_VH
`define FRT_CONSTS_VH

// register byte offsets (word aligned, decoded on haddr[5:0])
`define FRT_OFS_CTRL 6'h00
`define FRT_OFS_STATUS 6'h04
`define FRT_OFS_MASK 6'h08
`define FRT_OFS_COUNT 6'h0C
`define FRT_OFS_CMPA 6'h10
`define FRT_OFS_CMPB 6'h14
`define FRT_OFS_RISE 6'h18
`define FRT_OFS_FALL 6'h1C
`define FRT_OFS_CAPA 6'h20
`define FRT_OFS_CAPB 6'h24
`define FRT_OFS_CAPC 6'h28
`define FRT_OFS_CAPD 6'h2C
`define FRT_ADDR_W 6

// control register fields
`define FRT_CTRL_W 4
`define FRT_CTRL_CKS_LO 0
`define FRT_CTRL_CKS_HI 1
`define FRT_CTRL_AUTO 2
`define FRT_CTRL_CLR 3
`define FRT_CTRL_RST 4'h0

// clock select codes
`define FRT_CKS_INT0 2'h0
`define FRT_CKS_INT1 2'h1
`define FRT_CKS_INT2 2'h2

// prescaler taps: bit n toggles every 2**n system clocks
`define FRT_PS_W 6
`define FRT_PS_TAP0 1
`define FRT_PS_TAP1 3
`define FRT_PS_TAP2 5

// status / mask fields
`define FRT_ST_W 7
`define FRT_ST_CAP_LSB 0
`define FRT_ST_MATCH_A 4
`define FRT_ST_MATCH_B 5
`define FRT_ST_WRAP 6
`define FRT_ST_RST 7'h00
`define FRT_NCAP 4

// ahb
`define FRT_HTRANS_ACTIVE 1

`endif

// ---- src/frt_sync.v ----
`timescale 1ns/1ps
`default_nettype none

// three-stage pin synchroniser; output follows once stages 2 and 3 agree
module frt_sync #(
  parameter W = 5
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // pins and synchronised levels
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;
  integer i;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
      stage3 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      // a lone differing sample is treated as a glitch
      for (i = 0; i < W; i = i + 1)
      begin
        if (stage2[i] == stage3[i])
          dout[i] <= stage3[i];
      end
    end
  end

endmodule // frt_sync

`default_nettype wire

// ---- src/frt_timer.v ----
// How it works
// - clear right after counter write wins
// - increment right after counter write is dropped
// - match right after compare write is dropped
// - auto-add: writes suppress match and addition
// - count on falling edge of prescaled clock
// - clock-select rewrite is the switchover moment
// - old high, new low counts once
// - internal/external change may count once
// - capture sets flag, own interrupt
// - compare match sets flag, own interrupt
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "frt_consts.vh"

module frt_timer #(
  parameter CW = 16
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // pins
  input wire ext_clk_pin,
  input wire [`FRT_NCAP-1:0] capture_pin,
  output reg compare_out_a,
  // interrupts
  output wire irq,
  output wire [2:0] irq_top,
  output wire capture_irq_a,
  output wire capture_irq_b,
  output wire capture_irq_c,
  output wire capture_irq_d,
  output wire match_irq_a,
  output wire match_irq_b,
  output wire wrap_irq
);

  function hit;
    input [`FRT_ADDR_W-1:0] a;
    input [`FRT_ADDR_W-1:0] o;
    begin
      hit = (a == o);
    end
  endfunction

  // index of highest-priority pending source; wrap ranks last
  function [2:0] prio;
    input [`FRT_ST_W-1:0] v;
    integer k;
    begin
      prio = 3'h7;
      for (k = `FRT_ST_W - 1; k >= 0; k = k - 1)
      begin
        if (v[k])
          prio = k[2:0];
      end
    end
  endfunction

  // bus state
  reg dp_wr;
  reg dp_rd;
  reg rd_wait;
  reg [`FRT_ADDR_W-1:0] dp_addr;
  wire addr_ok;
  wire rd_status;
  reg [31:0] next_rdata;

  // registers
  reg [`FRT_CTRL_W-1:0] ctrl;
  reg [`FRT_ST_W-1:0] status;
  reg [`FRT_ST_W-1:0] mask;
  reg [CW-1:0] free_running_counter;
  reg [CW-1:0] compare_reg_a;
  reg [CW-1:0] compare_reg_b;
  reg [CW-1:0] rise_addend_reg;
  reg [CW-1:0] fall_addend_reg;
  reg [CW-1:0] cap_reg [0:`FRT_NCAP-1];

  // write strobes, and one-cycle-late copies of all but wr_ctrl and wr_mask
  wire wr_ctrl;
  wire wr_mask;
  wire wr_count;
  wire wr_cmpa;
  wire wr_cmpb;
  wire wr_rise;
  wire wr_fall;
  reg wr_count_d;
  reg wr_cmpa_d;
  reg wr_cmpb_d;
  reg wr_rise_d;
  reg wr_fall_d;

  // count clock
  reg [`FRT_PS_W-1:0] presc;
  reg src_level;
  reg src_level_d;
  wire tick;
  wire [`FRT_NCAP:0] pins_s;
  wire ext_s;
  wire [`FRT_NCAP-1:0] cap_s;
  reg [`FRT_NCAP-1:0] cap_s_d;
  wire [`FRT_NCAP-1:0] cap_evt;

  // compare and events
  wire eq_a;
  wire eq_b;
  reg eq_a_d;
  reg eq_b_d;
  wire auto_add;
  wire supp_a;
  wire match_a;
  wire match_b;
  wire clr_evt;
  wire inc_ok;
  wire wrap_evt;
  wire [`FRT_ST_W-1:0] set_v;
  wire [`FRT_ST_W-1:0] irq_v;
  integer i;

  // ---- ahb-lite slave: writes zero-wait, reads one wait state
  assign addr_ok = hsel & htrans[`FRT_HTRANS_ACTIVE] & hready;
  assign hreadyout = ~rd_wait;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      rd_wait <= 1'b0;
      dp_addr <= {`FRT_ADDR_W{1'b0}};
    end
    else
    begin
      if (hready)
      begin
        dp_wr <= addr_ok & hwrite;
        dp_rd <= addr_ok & ~hwrite;
        dp_addr <= haddr[`FRT_ADDR_W-1:0];
      end
      // wait state lets a preceding write land before the read samples
      rd_wait <= addr_ok & ~hwrite & ~rd_wait;
    end
  end

  assign wr_ctrl = dp_wr & hit(dp_addr, `FRT_OFS_CTRL);
  assign wr_mask = dp_wr & hit(dp_addr, `FRT_OFS_MASK);
  assign wr_count = dp_wr & hit(dp_addr, `FRT_OFS_COUNT);
  assign wr_cmpa = dp_wr & hit(dp_addr, `FRT_OFS_CMPA);
  assign wr_cmpb = dp_wr & hit(dp_addr, `FRT_OFS_CMPB);
  assign wr_rise = dp_wr & hit(dp_addr, `FRT_OFS_RISE);
  assign wr_fall = dp_wr & hit(dp_addr, `FRT_OFS_FALL);
  assign rd_status = rd_wait & dp_rd & hit(dp_addr, `FRT_OFS_STATUS);

  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (dp_addr)
      `FRT_OFS_CTRL: next_rdata = {{(32-`FRT_CTRL_W){1'b0}}, ctrl};
      `FRT_OFS_STATUS: next_rdata = {{(32-`FRT_ST_W){1'b0}}, status};
      `FRT_OFS_MASK: next_rdata = {{(32-`FRT_ST_W){1'b0}}, mask};
      `FRT_OFS_COUNT: next_rdata = {{(32-CW){1'b0}}, free_running_counter};
      `FRT_OFS_CMPA: next_rdata = {{(32-CW){1'b0}}, compare_reg_a};
      `FRT_OFS_CMPB: next_rdata = {{(32-CW){1'b0}}, compare_reg_b};
      `FRT_OFS_RISE: next_rdata = {{(32-CW){1'b0}}, rise_addend_reg};
      `FRT_OFS_FALL: next_rdata = {{(32-CW){1'b0}}, fall_addend_reg};
      `FRT_OFS_CAPA: next_rdata = {{(32-CW){1'b0}}, cap_reg[0]};
      `FRT_OFS_CAPB: next_rdata = {{(32-CW){1'b0}}, cap_reg[1]};
      `FRT_OFS_CAPC: next_rdata = {{(32-CW){1'b0}}, cap_reg[2]};
      `FRT_OFS_CAPD: next_rdata = {{(32-CW){1'b0}}, cap_reg[3]};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_wait)
      hrdata <= next_rdata;
  end

  // ---- control, mask and late write strobes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= `FRT_CTRL_RST;
      mask <= `FRT_ST_RST;
      wr_count_d <= 1'b0;
      wr_cmpa_d <= 1'b0;
      wr_cmpb_d <= 1'b0;
      wr_rise_d <= 1'b0;
      wr_fall_d <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= hwdata[`FRT_CTRL_W-1:0];
      if (wr_mask)
        mask <= hwdata[`FRT_ST_W-1:0];
      wr_count_d <= wr_count;
      wr_cmpa_d <= wr_cmpa;
      wr_cmpb_d <= wr_cmpb;
      wr_rise_d <= wr_rise;
      wr_fall_d <= wr_fall;
    end
  end

  assign auto_add = ctrl[`FRT_CTRL_AUTO];

  // ---- pins and count clock
  frt_sync #(
    .W(`FRT_NCAP + 1)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({ext_clk_pin, capture_pin}),
    .dout(pins_s)
  );

  assign ext_s = pins_s[`FRT_NCAP];
  assign cap_s = pins_s[`FRT_NCAP-1:0];

  always @*
  begin
    case ({ctrl[`FRT_CTRL_CKS_HI], ctrl[`FRT_CTRL_CKS_LO]})
      `FRT_CKS_INT0: src_level = presc[`FRT_PS_TAP0];
      `FRT_CKS_INT1: src_level = presc[`FRT_PS_TAP1];
      `FRT_CKS_INT2: src_level = presc[`FRT_PS_TAP2];
      default: src_level = ext_s;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      presc <= {`FRT_PS_W{1'b0}};
      src_level_d <= 1'b0;
      cap_s_d <= {`FRT_NCAP{1'b0}};
    end
    else
    begin
      presc <= presc + 1'b1;
      // holds the old source's level across a select rewrite
      src_level_d <= src_level;
      cap_s_d <= cap_s;
    end
  end

  // falling edge of the selected level
  // old high vs new low reads as a fall
  assign tick = src_level_d & ~src_level;

  // ---- compare logic
  assign eq_a = (free_running_counter == compare_reg_a);
  assign eq_b = (free_running_counter == compare_reg_b);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      eq_a_d <= 1'b0;
      eq_b_d <= 1'b0;
    end
    else
    begin
      eq_a_d <= eq_a;
      eq_b_d <= eq_b;
    end
  end

  // write just before a match masks it
  // in auto-add mode, addend writes also mask match A
  assign supp_a = wr_cmpa_d | (auto_add & (wr_rise_d | wr_fall_d));
  assign match_a = eq_a & ~eq_a_d & ~supp_a;
  assign match_b = eq_b & ~eq_b_d & ~wr_cmpb_d;
  assign clr_evt = match_a & ctrl[`FRT_CTRL_CLR];

  // ---- free-running counter
  // no increment in the cycle after a write
  assign inc_ok = tick & ~wr_count_d & ~wr_count & ~clr_evt;
  assign wrap_evt = inc_ok & (&free_running_counter);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      free_running_counter <= {CW{1'b0}};
    else if (wr_count)
      free_running_counter <= hwdata[CW-1:0];
    else if (clr_evt)
      free_running_counter <= {CW{1'b0}};
    else if (inc_ok)
      free_running_counter <= free_running_counter + 1'b1;
  end

  // ---- compare registers, addends, output level
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      compare_reg_a <= {CW{1'b1}};
      compare_reg_b <= {CW{1'b1}};
      rise_addend_reg <= {CW{1'b0}};
      fall_addend_reg <= {CW{1'b0}};
      compare_out_a <= 1'b0;
    end
    else
    begin
      if (wr_cmpa)
        compare_reg_a <= hwdata[CW-1:0];
      // addend picked by the level about to be driven
      // suppressed match leaves compare A untouched
      else if (match_a & auto_add)
        compare_reg_a <= compare_reg_a +
          (compare_out_a ? fall_addend_reg : rise_addend_reg);
      if (wr_cmpb)
        compare_reg_b <= hwdata[CW-1:0];
      if (wr_rise)
        rise_addend_reg <= hwdata[CW-1:0];
      if (wr_fall)
        fall_addend_reg <= hwdata[CW-1:0];
      if (match_a)
        compare_out_a <= ~compare_out_a;
    end
  end

  // ---- input capture on rising pin edges
  assign cap_evt = cap_s & ~cap_s_d;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (i = 0; i < `FRT_NCAP; i = i + 1)
        cap_reg[i] <= {CW{1'b0}};
    end
    else
    begin
      for (i = 0; i < `FRT_NCAP; i = i + 1)
      begin
        if (cap_evt[i])
          cap_reg[i] <= free_running_counter;
      end
    end
  end

  // ---- sticky flags, read of status clears, set beats clear
  // one flag per capture
  assign set_v = {wrap_evt, match_b, match_a, cap_evt};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status <= `FRT_ST_RST;
    else if (rd_status)
      status <= set_v;
    else
      status <= status | set_v;
  end

  assign irq_v = status & mask;
  assign irq = |irq_v;
  // wrap ranks below every other source
  assign irq_top = prio(irq_v);
  assign capture_irq_a = irq_v[`FRT_ST_CAP_LSB];
  assign capture_irq_b = irq_v[`FRT_ST_CAP_LSB + 1];
  assign capture_irq_c = irq_v[`FRT_ST_CAP_LSB + 2];
  assign capture_irq_d = irq_v[`FRT_ST_CAP_LSB + 3];
  assign match_irq_a = irq_v[`FRT_ST_MATCH_A];
  assign match_irq_b = irq_v[`FRT_ST_MATCH_B];
  assign wrap_irq = irq_v[`FRT_ST_WRAP];

  // hsize unused: only whole-word transfers are supported
  wire unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[31:`FRT_ADDR_W], dp_rd};

endmodule // frt_timer

`default_nettype wire

// ---- tb/frt_timer_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module frt_timer_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // interrupts
  input wire logic irq,
  input wire logic [2:0] irq_top,
  input wire logic capture_irq_a,
  input wire logic capture_irq_b,
  input wire logic capture_irq_c,
  input wire logic capture_irq_d,
  input wire logic match_irq_a,
  input wire logic match_irq_b,
  input wire logic wrap_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic take = hsel && htrans[1] && hready;
  wire logic any_cap = capture_irq_a || capture_irq_b || capture_irq_c ||
    capture_irq_d;

  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_fast: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_irq_any: assert property (
    irq == (any_cap || match_irq_a || match_irq_b || wrap_irq))
    else $error("irq not the or of its sources");
  a_top_none: assert property ((irq_top == 3'h7) == !irq)
    else $error("irq index disagrees with irq");
  a_top_cap_a: assert property (capture_irq_a |-> irq_top == 3'h0)
    else $error("capture a not on top");
  a_top_match: assert property (
    match_irq_a && !any_cap |-> irq_top == 3'h4)
    else $error("match a index wrong");
  a_wrap_last: assert property (
    irq_top == 3'h6 |-> wrap_irq && !any_cap && !match_irq_a && !match_irq_b)
    else $error("wrap placed above another source");
  // irq only drops after a status read or a mask write, two edges on
  a_irq_fall: assert property ($fell(irq) |-> $past(take, 2))
    else $error("irq dropped without a bus access");
endmodule // frt_timer_chk

bind frt_timer frt_timer_chk i_chk (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .irq, .irq_top,
  .capture_irq_a, .capture_irq_b, .capture_irq_c, .capture_irq_d,
  .match_irq_a, .match_irq_b, .wrap_irq);
`default_nettype wire

// ---- tb/frt_timer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "frt_consts.vh"
module frt_timer_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic ext = 1'b0;
  logic [3:0] cap = 4'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic out_a;
  wire logic irq;
  wire logic [2:0] irq_top;
  wire logic [6:0] lines;
  logic [31:0] rdv;
  int n_fail = 0;
  int samples_checked = 0;
  int cnt = 0;
  int ones;

  frt_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .ext_clk_pin(ext), .capture_pin(cap),
    .compare_out_a(out_a), .irq(irq), .irq_top(irq_top),
    .capture_irq_a(lines[0]), .capture_irq_b(lines[1]),
    .capture_irq_c(lines[2]), .capture_irq_d(lines[3]),
    .match_irq_a(lines[4]), .match_irq_b(lines[5]), .wrap_irq(lines[6]));

  always #50 hclk = ~hclk;
  always @(posedge hclk) cnt <= cnt + 1;

  task automatic end_sim;
    $display("checked %0d bad %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // hsel stays up between transfers so no signal is set twice per step
  task automatic xfer(input logic w, input logic [5:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {26'h000_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic ck(input logic [5:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    cmp(rdv, e);
  endtask

  // slow pulses: the pin is resynchronised, so a tick lands some edges late
  task automatic tick(input int n);
    repeat (n)
    begin
      ext <= 1'b1;
      repeat (4) @(posedge hclk);
      ext <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
  endtask

  task automatic td(input string s);
    $display("test %0s done", s);
  endtask

  initial
  begin
    repeat (6000) @(posedge hclk);
    n_fail++;
    end_sim;
  end

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // counter runs from reset, so its value is skipped here
    for (int i = 0; i < 13; i++)
      if (i != 3)
        ck(6'(i * 4), (i == 4 || i == 5) ? 32'h0000_ffff : 32'h0000_0000);
    wr(`FRT_OFS_CAPA, 32'h0000_1234);
    ck(`FRT_OFS_CAPA, 32'h0000_0000);
    td("reset");
    wr(`FRT_OFS_CTRL, 32'h0000_0003);
    wr(`FRT_OFS_COUNT, 32'h0000_0000);
    tick(5);
    ck(`FRT_OFS_COUNT, 32'h0000_0005);
    wr(`FRT_OFS_MASK, 32'h0000_007f);
    wr(`FRT_OFS_COUNT, 32'h0000_fffe);
    tick(3);
    ck(`FRT_OFS_COUNT, 32'h0000_0001);
    cmp(32'(lines), 32'h0000_0070);
    cmp(32'(irq_top), 32'h0000_0004);
    cmp(32'(out_a), 32'h0000_0001);
    wr(`FRT_OFS_MASK, 32'h0000_0000);
    @(posedge hclk);
    cmp(32'(irq), 32'h0000_0000);
    wr(`FRT_OFS_MASK, 32'h0000_007f);
    ck(`FRT_OFS_STATUS, 32'h0000_0070);
    ck(`FRT_OFS_STATUS, 32'h0000_0000);
    td("count and wrap");
    wr(`FRT_OFS_CTRL, 32'h0000_000b);
    wr(`FRT_OFS_CMPA, 32'h0000_0100);
    wr(`FRT_OFS_COUNT, 32'h0000_0100);
    repeat (2) @(posedge hclk);
    ck(`FRT_OFS_COUNT, 32'h0000_0000);
    ck(`FRT_OFS_STATUS, 32'h0000_0010);
    td("clear wins");
    wr(`FRT_OFS_CTRL, 32'h0000_0003);
    wr(`FRT_OFS_CMPB, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    ck(`FRT_OFS_STATUS, 32'h0000_0000);
    tick(1);
    wr(`FRT_OFS_CMPB, 32'h0000_0002);
    tick(1);
    ck(`FRT_OFS_STATUS, 32'h0000_0020);
    td("compare write");
    wr(`FRT_OFS_CTRL, 32'h0000_0007);
    wr(`FRT_OFS_RISE, 32'h0000_0003);
    wr(`FRT_OFS_FALL, 32'h0000_0005);
    wr(`FRT_OFS_CMPA, 32'h0000_0002);
    repeat (2) @(posedge hclk);
    ck(`FRT_OFS_CMPA, 32'h0000_0002);
    ck(`FRT_OFS_STATUS, 32'h0000_0000);
    cmp(32'(out_a), 32'h0000_0000);
    wr(`FRT_OFS_CMPA, 32'h0000_0004);
    tick(2);
    ck(`FRT_OFS_CMPA, 32'h0000_0007);
    cmp(32'(out_a), 32'h0000_0001);
    tick(3);
    ck(`FRT_OFS_CMPA, 32'h0000_000c);
    cmp(32'(out_a), 32'h0000_0000);
    ck(`FRT_OFS_STATUS, 32'h0000_0010);
    td("auto add");
    for (int i = 0; i < 4; i++)
    begin
      cap <= 4'(1 << i);
      repeat (8) @(posedge hclk);
      cap <= 4'h0;
      cmp(32'(lines), 32'(1 << i));
      cmp(32'(irq_top), 32'(i));
      ck(6'(32 + 4 * i), 32'h0000_0007);
      ck(`FRT_OFS_STATUS, 32'(1 << i));
    end
    td("capture");
    // pin fall lands as a tick exactly in the cycle after the write
    ext <= 1'b1;
    repeat (8) @(posedge hclk);
    ext <= 1'b0;
    repeat (2) @(posedge hclk);
    wr(`FRT_OFS_COUNT, 32'h0000_0050);
    ck(`FRT_OFS_COUNT, 32'h0000_0050);
    td("write beats tick");
    wr(`FRT_OFS_CTRL, 32'h0000_0000);
    wr(`FRT_OFS_COUNT, 32'h0000_0000);
    repeat (40) @(posedge hclk);
    xfer(1'b0, `FRT_OFS_COUNT, 32'h0000_0000);
    cmp(32'(rdv >= 9 && rdv <= 12), 32'h0000_0001);
    td("prescaler");
    // four switchovers a quarter period apart: two meet a low new source
    ext <= 1'b1;
    ones = 0;
    for (int k = 0; k < 4; k++)
    begin
      wr(`FRT_OFS_CTRL, 32'h0000_0003);
      wr(`FRT_OFS_COUNT, 32'h0000_0000);
      while (cnt % 64 != 16 * k) @(posedge hclk);
      wr(`FRT_OFS_CTRL, 32'h0000_0002);
      repeat (3) @(posedge hclk);
      xfer(1'b0, `FRT_OFS_COUNT, 32'h0000_0000);
      if (rdv != 0)
        ones++;
    end
    cmp(32'(ones >= 2), 32'h0000_0001);
    td("switchover");
    end_sim;
  end
endmodule // frt_timer_tb
`default_nettype wire
